// ### dual_timer_regs.svh
// Purpose: Constants for the dual timer with capture/reload
// Assumes: 16-bit timers, 10 MHz system clock
// Notes: Prescaler select is a power of two exponent
`ifndef DUAL_TIMER_REGS_SVH
`define DUAL_TIMER_REGS_SVH
`define TMR_WIDTH 16
`define TMR_RESET 16'h0000
`define PRE_WIDTH 3
`define PRE_CNT_WIDTH 8
`define MIN_DIV_CYCLES 2
`endif

// ### dual_timer_pkg.sv
// Purpose: Types for the dual timer with capture/reload
// Assumes: Used with dual_timer_regs.svh
// Notes: Clock source selections per timer
package dual_timer_pkg;
  typedef enum logic [1:0] {
    SRC_PRESCALE,
    SRC_EXT_RISE,
    SRC_EXT_FALL,
    SRC_TOGGLE
  } clk_src_t;
  typedef enum logic [1:0] {
    EDGE_NONE,
    EDGE_RISE,
    EDGE_FALL,
    EDGE_BOTH
  } edge_sel_t;
endpackage

// ### dual_timer_capture_reload.sv
// Purpose: Core timer and auxiliary timer with a shared capture/reload register
// Assumes: Pins are asynchronous and pass two flip-flops first
// Notes: Control bits are plain ports; no bus, no interrupts
// Notes: A pin count edge seen in the idle cycle of the 2-cycle phase is dropped, not delayed
`include "dual_timer_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module dual_timer_capture_reload (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_CORE_RUN,
  input wire logic I_AUX_RUN,
  input wire dual_timer_pkg::clk_src_t I_CORE_SRC,
  input wire dual_timer_pkg::clk_src_t I_AUX_SRC,
  input wire logic [`PRE_WIDTH-1:0] I_CORE_PRE,
  input wire logic [`PRE_WIDTH-1:0] I_AUX_PRE,
  input wire logic I_CORE_DOWN,
  input wire logic I_AUX_DOWN,
  input wire logic I_CORE_DIR_PIN_EN,
  input wire logic I_AUX_DIR_PIN_EN,
  input wire logic I_CORE_CLK_PIN,
  input wire logic I_AUX_CLK_PIN,
  input wire logic I_CORE_DIR_PIN,
  input wire logic I_AUX_DIR_PIN,
  input wire logic I_TOGGLE_OUT_EN,
  input wire logic I_RELOAD_EN,
  input wire dual_timer_pkg::edge_sel_t I_CAP_EDGE,
  input wire logic I_CAP_CLEAR_EN,
  input wire logic I_PEER_CNT_CAP_EN,
  input wire logic I_PEER_DIR_CAP_EN,
  input wire logic I_CAPTURE_PIN,
  input wire logic I_PEER_CNT_PIN,
  input wire logic I_PEER_DIR_PIN,
  output logic [`TMR_WIDTH-1:0] O_CORE_TIMER,
  output logic [`TMR_WIDTH-1:0] O_AUX_TIMER,
  output logic [`TMR_WIDTH-1:0] O_CAPTURE_RELOAD,
  output logic O_TOGGLE_LATCH,
  output logic O_TOGGLE_PIN,
  output logic O_COMPARE_CLK,
  output logic O_CAPTURE_EVT
);
  localparam int NPIN = 7;
  // Pin order: core clk, aux clk, core dir, aux dir, capture, peer cnt, peer dir
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1;
  logic [NPIN-1:0] sync2;
  logic [NPIN-1:0] sync3;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] fall;
  logic phase;
  logic next_phase;
  logic [`PRE_CNT_WIDTH-1:0] pre_cnt;
  logic [`PRE_CNT_WIDTH-1:0] next_pre_cnt;
  logic [`TMR_WIDTH-1:0] core_timer;
  logic [`TMR_WIDTH-1:0] aux_timer;
  logic [`TMR_WIDTH-1:0] capture_reload_reg;
  logic [`TMR_WIDTH-1:0] next_core_timer;
  logic [`TMR_WIDTH-1:0] next_aux_timer;
  logic [`TMR_WIDTH-1:0] next_capture_reload_reg;
  logic core_toggle_latch;
  logic next_core_toggle_latch;
  logic latch_prev;
  logic next_latch_prev;
  logic next_compare_clk;
  logic next_capture_evt;
  logic core_tick;
  logic aux_tick;
  logic core_down;
  logic aux_down;
  logic core_wrap;
  logic latch_edge;
  logic capture;

  assign pin_raw = {I_PEER_DIR_PIN, I_PEER_CNT_PIN, I_CAPTURE_PIN, I_AUX_DIR_PIN,
                    I_CORE_DIR_PIN, I_AUX_CLK_PIN, I_CORE_CLK_PIN};

  // Two-stage synchronisers plus one history stage for edge detection
  // A pin change reaches the edge logic 2 cycles after it happens
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin
      always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync3[g] <= 1'b0;
        end else begin
          sync1[g] <= pin_raw[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
        end
      end
      assign rise[g] = sync2[g] & ~sync3[g];
      assign fall[g] = ~sync2[g] & sync3[g];
    end
  endgenerate

  // Select a count tick from the source setting
  // The core has no toggle source, so it is handed a constant low there
  function automatic logic pick_tick(input dual_timer_pkg::clk_src_t src, input logic pre_hit,
                                     input logic r, input logic f, input logic tgl);
    logic t;
    t = 1'b0;
    unique case (src)
      dual_timer_pkg::SRC_PRESCALE: t = pre_hit;
      dual_timer_pkg::SRC_EXT_RISE: t = r;
      dual_timer_pkg::SRC_EXT_FALL: t = f;
      dual_timer_pkg::SRC_TOGGLE: t = tgl;
    endcase
    return t;
  endfunction

  // Counting only on odd phase caps the rate at one count per two cycles; pin edges on even phase are lost
  // Gating both timers by phase keeps the toggle-to-aux path aligned too
  always_comb begin
    next_phase = ~phase;
    next_pre_cnt = pre_cnt + (phase ? `PRE_CNT_WIDTH'(1) : `PRE_CNT_WIDTH'(0));
    // The latch history only moves in the counting phase, so a latch change that lands
    // in the idle phase is still seen as an edge at the next counting cycle
    next_latch_prev = phase ? core_toggle_latch : latch_prev;
    latch_edge = core_toggle_latch ^ latch_prev;
    core_tick = phase & I_CORE_RUN & pick_tick(I_CORE_SRC,
        (pre_cnt & ((`PRE_CNT_WIDTH'(1) << I_CORE_PRE) - `PRE_CNT_WIDTH'(1))) == '0,
        rise[0], fall[0], 1'b0);
    aux_tick = phase & I_AUX_RUN & pick_tick(I_AUX_SRC,
        (pre_cnt & ((`PRE_CNT_WIDTH'(1) << I_AUX_PRE) - `PRE_CNT_WIDTH'(1))) == '0,
        rise[1], fall[1], latch_edge);
    core_down = I_CORE_DIR_PIN_EN ? (sync2[2] ^ I_CORE_DOWN) : I_CORE_DOWN;
    aux_down = I_AUX_DIR_PIN_EN ? (sync2[3] ^ I_AUX_DOWN) : I_AUX_DOWN;
  end

  // Core timer, toggle latch and reload
  // Wrap is judged before the step: all ones going up, zero going down
  // A reload replaces the wrapped value, but the latch and compare pulse still see the wrap
  always_comb begin
    next_core_timer = core_timer;
    next_core_toggle_latch = core_toggle_latch;
    core_wrap = 1'b0;
    if (core_tick) begin
      core_wrap = core_down ? (core_timer == '0) : (core_timer == '1);
      next_core_timer = core_down ? core_timer - `TMR_WIDTH'(1) : core_timer + `TMR_WIDTH'(1);
      if (core_wrap) begin
        next_core_toggle_latch = ~core_toggle_latch;
        if (I_RELOAD_EN) begin
          next_core_timer = capture_reload_reg;
        end
      end
    end
    next_compare_clk = core_wrap;
  end

  // Capture sources; aux clear wins over counting in the capture cycle
  // The capture takes the aux value from before this cycle's count or clear
  always_comb begin
    capture = 1'b0;
    unique case (I_CAP_EDGE)
      dual_timer_pkg::EDGE_NONE: capture = 1'b0;
      dual_timer_pkg::EDGE_RISE: capture = rise[4];
      dual_timer_pkg::EDGE_FALL: capture = fall[4];
      dual_timer_pkg::EDGE_BOTH: capture = rise[4] | fall[4];
    endcase
    capture = capture | (I_PEER_CNT_CAP_EN & (rise[5] | fall[5]))
                      | (I_PEER_DIR_CAP_EN & (rise[6] | fall[6]));
    next_capture_reload_reg = capture ? aux_timer : capture_reload_reg;
    next_aux_timer = aux_timer;
    if (aux_tick) begin
      next_aux_timer = aux_down ? aux_timer - `TMR_WIDTH'(1) : aux_timer + `TMR_WIDTH'(1);
    end
    if (capture && I_CAP_CLEAR_EN) begin
      next_aux_timer = `TMR_RESET;
    end
    next_capture_evt = capture;
  end

  // State registers
  // Reset clears every count; pin history starts at the idle low level
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      phase <= 1'b0;
      pre_cnt <= '0;
      core_timer <= `TMR_RESET;
      aux_timer <= `TMR_RESET;
      capture_reload_reg <= `TMR_RESET;
      core_toggle_latch <= 1'b0;
      latch_prev <= 1'b0;
      O_COMPARE_CLK <= 1'b0;
      O_CAPTURE_EVT <= 1'b0;
      O_TOGGLE_PIN <= 1'b0;
    end else begin
      phase <= next_phase;
      pre_cnt <= next_pre_cnt;
      core_timer <= next_core_timer;
      aux_timer <= next_aux_timer;
      capture_reload_reg <= next_capture_reload_reg;
      core_toggle_latch <= next_core_toggle_latch;
      latch_prev <= next_latch_prev;
      O_COMPARE_CLK <= next_compare_clk;
      O_CAPTURE_EVT <= next_capture_evt;
      // Registered so the pin never glitches; the enable takes effect one cycle late
      O_TOGGLE_PIN <= next_core_toggle_latch & I_TOGGLE_OUT_EN;
    end
  end

  // Outputs come straight from the state registers
  assign O_CORE_TIMER = core_timer;
  assign O_AUX_TIMER = aux_timer;
  assign O_CAPTURE_RELOAD = capture_reload_reg;
  assign O_TOGGLE_LATCH = core_toggle_latch;
endmodule
`default_nettype wire

// ### far_side_pins.sv
// Purpose: Far-side pin model for the dual timer
// Assumes: Pins change 10 ns after a clock edge
// Notes: Edges 4 cycles apart, slower than the count rate
`timescale 1ns/1ps
`default_nettype none
module far_side_pins (
  input wire logic i_clk,
  output logic [6:0] o_pins
);
  initial o_pins = 7'h00;
  // One edge, then held long enough for the synchronisers to see it
  task automatic flip(input int idx);
    @(posedge i_clk);
    #10 o_pins[idx] = ~o_pins[idx];
    repeat (3) @(posedge i_clk);
    #10;
  endtask
endmodule
`default_nettype wire

// ### dual_timer_properties.sv
// Purpose: Port checks for the dual timer
// Assumes: One clock, async active-low reset
// Notes: Bound to the top module below
`timescale 1ns/1ps
`default_nettype none
module dual_timer_properties (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_RELOAD_EN,
  input wire logic I_TOGGLE_OUT_EN,
  input wire logic I_CAP_CLEAR_EN,
  input wire logic [15:0] O_CORE_TIMER,
  input wire logic [15:0] O_AUX_TIMER,
  input wire logic [15:0] O_CAPTURE_RELOAD,
  input wire logic O_TOGGLE_LATCH,
  input wire logic O_TOGGLE_PIN,
  input wire logic O_COMPARE_CLK,
  input wire logic O_CAPTURE_EVT
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  // Wrap and reload are split, since a reload replaces the wrap value
  chk_core_rate: assert property ($changed(O_CORE_TIMER) |=> $stable(O_CORE_TIMER))
    else $error("core rate");
  chk_latch_wrap: assert property ($changed(O_TOGGLE_LATCH) == O_COMPARE_CLK)
    else $error("latch");
  chk_wrap_value: assert property (O_COMPARE_CLK && !$past(I_RELOAD_EN)
    |-> O_CORE_TIMER inside {16'h0000, 16'hffff}) else $error("wrap");
  chk_reload_load: assert property (O_COMPARE_CLK && $past(I_RELOAD_EN)
    |-> O_CORE_TIMER == $past(O_CAPTURE_RELOAD)) else $error("reload");
  chk_cap_source: assert property ($changed(O_CAPTURE_RELOAD) |-> O_CAPTURE_EVT)
    else $error("capture cause");
  chk_cap_value: assert property (O_CAPTURE_EVT |-> O_CAPTURE_RELOAD == $past(O_AUX_TIMER))
    else $error("capture value");
  chk_cap_clear: assert property (O_CAPTURE_EVT && $past(I_CAP_CLEAR_EN) |-> O_AUX_TIMER == 16'h0000)
    else $error("clear");
  chk_pin_gate: assert property (O_TOGGLE_PIN == (O_TOGGLE_LATCH && $past(I_TOGGLE_OUT_EN)))
    else $error("pin");
  cover property (O_CAPTURE_EVT);
  cover property (O_COMPARE_CLK && I_RELOAD_EN);
  cover property (O_TOGGLE_PIN);
endmodule
bind dual_timer_capture_reload dual_timer_properties u_chk (.*);
`default_nettype wire

// ### dual_timer_capture_reload_test.sv
// Purpose: Self-checking bench for the dual timer
// Assumes: Far-side pins come from far_side_pins
// Notes: Per-cycle relations are left to the checker
`timescale 1ns/1ps
`default_nettype none
module dual_timer_capture_reload_test;
  // Port-named signals so the instance connects by name
  logic I_CLK = 1'h0, I_RST_N = 1'h0, I_CORE_RUN = 1'h0, I_AUX_RUN = 1'h0, I_CORE_DOWN = 1'h0, I_AUX_DOWN = 1'h0;
  logic I_CORE_DIR_PIN_EN = 1'h0, I_AUX_DIR_PIN_EN = 1'h0, I_TOGGLE_OUT_EN = 1'h0, I_RELOAD_EN = 1'h0;
  logic I_CAP_CLEAR_EN = 1'h1, I_PEER_CNT_CAP_EN = 1'h0, I_PEER_DIR_CAP_EN = 1'h0;
  logic [2:0] I_CORE_PRE = 3'h0, I_AUX_PRE = 3'h0;
  dual_timer_pkg::clk_src_t I_CORE_SRC = dual_timer_pkg::SRC_PRESCALE, I_AUX_SRC = dual_timer_pkg::SRC_EXT_RISE;
  dual_timer_pkg::edge_sel_t I_CAP_EDGE = dual_timer_pkg::EDGE_RISE;
  wire logic [6:0] pins;
  logic [15:0] O_CORE_TIMER, O_AUX_TIMER, O_CAPTURE_RELOAD, v;
  logic O_TOGGLE_LATCH, O_TOGGLE_PIN, O_COMPARE_CLK, O_CAPTURE_EVT;
  int fail_count = 0, checked = 0;
  always #50 I_CLK = ~I_CLK;
  far_side_pins u_pins (.i_clk(I_CLK), .o_pins(pins));
  dual_timer_capture_reload u_dut (.I_CAPTURE_PIN(pins[6]), .I_PEER_CNT_PIN(pins[5]), .I_PEER_DIR_PIN(pins[4]),
    .I_CORE_CLK_PIN(pins[3]), .I_AUX_CLK_PIN(pins[2]), .I_CORE_DIR_PIN(pins[1]), .I_AUX_DIR_PIN(pins[0]), .*);
  // Four-state compare so an unknown never passes
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge I_CLK);
    #10;
  endtask
  // Bounded wait: compare pulse when sel, else capture event
  task automatic wait_hi(input logic sel);
    int i;
    for (i = 0; i < 40 && (sel ? O_COMPARE_CLK : O_CAPTURE_EVT) !== 1'h1; i++) step(1);
    if (i == 40) begin
      chk("pulse wait", 16'h0000, 16'h0001);
      complete_run();
    end
  endtask
  // Align to a core tick, then expect one step of d a tick later
  task automatic delta(input logic [15:0] d);
    step(6);
    v = O_CORE_TIMER;
    step(1);
    if (O_CORE_TIMER === v) step(1);
    v = O_CORE_TIMER;
    step(2);
    chk("core step", O_CORE_TIMER, v + d);
  endtask
  // Bounded wait for the next core count
  task automatic wait_core_step();
    int i;
    logic [15:0] w;
    w = O_CORE_TIMER;
    for (i = 0; i < 8 && O_CORE_TIMER === w; i++) step(1);
    if (i == 8) begin
      chk("core step wait", 16'h0000, 16'h0001);
      complete_run();
    end
  endtask
  task automatic test_count();
    I_CORE_RUN = 1'h1;
    delta(16'h0001);
    I_CORE_DOWN = 1'h1;
    delta(16'hffff);
    I_CORE_DIR_PIN_EN = 1'h1;
    u_pins.flip(1);
    delta(16'h0001);
    I_CORE_RUN = 1'h0;
    I_CORE_DIR_PIN_EN = 1'h0;
    $display("count done");
  endtask
  task automatic test_capture();
    I_AUX_DOWN = 1'h1;
    I_AUX_DIR_PIN_EN = 1'h1;
    u_pins.flip(0);
    I_AUX_RUN = 1'h1;
    repeat (10) u_pins.flip(2);
    step(4);
    chk("aux count", O_AUX_TIMER, 16'h0005);
    u_pins.flip(6);
    wait_hi(1'h0);
    chk("capture", O_CAPTURE_RELOAD, 16'h0005);
    chk("aux clear", O_AUX_TIMER, 16'h0000);
    repeat (6) u_pins.flip(2);
    I_PEER_CNT_CAP_EN = 1'h1;
    u_pins.flip(5);
    wait_hi(1'h0);
    chk("peer count capture", O_CAPTURE_RELOAD, 16'h0003);
    I_PEER_CNT_CAP_EN = 1'h0;
    I_PEER_DIR_CAP_EN = 1'h1;
    repeat (4) u_pins.flip(2);
    u_pins.flip(4);
    wait_hi(1'h0);
    chk("peer dir capture", O_CAPTURE_RELOAD, 16'h0002);
    $display("capture done");
  endtask
  // Direction picked so the wrap comes within a few ticks
  task automatic test_wrap();
    logic l;
    I_AUX_SRC = dual_timer_pkg::SRC_TOGGLE;
    I_TOGGLE_OUT_EN = 1'h1;
    I_RELOAD_EN = 1'h1;
    I_CORE_DOWN = !O_CORE_TIMER[15];
    l = O_TOGGLE_LATCH;
    step(1);
    I_CORE_RUN = 1'h1;
    wait_hi(1'h1);
    chk("reload", O_CORE_TIMER, 16'h0002);
    chk("latch", O_TOGGLE_LATCH, {15'h0000, !l});
    chk("toggle pin", {15'h0000, O_TOGGLE_PIN}, 16'h0001);
    step(4);
    chk("aux from latch", O_AUX_TIMER, 16'h0001);
    $display("wrap done");
  endtask
  // Prescaler of 4 cycles a count, falling-edge core clock, then capture edge choices with no clear
  task automatic test_alt_source();
    logic [15:0] va;
    I_RELOAD_EN = 1'h0;
    I_CORE_DOWN = 1'h0;
    I_CORE_PRE = 3'h1;
    I_AUX_PRE = 3'h1;
    I_AUX_SRC = dual_timer_pkg::SRC_PRESCALE;
    wait_core_step();
    v = O_CORE_TIMER;
    va = O_AUX_TIMER;
    step(4);
    chk("core prescaled", O_CORE_TIMER, v + 16'h0001);
    chk("aux prescaled", O_AUX_TIMER, va + 16'h0001);
    I_AUX_RUN = 1'h0;
    I_CORE_SRC = dual_timer_pkg::SRC_EXT_FALL;
    v = O_CORE_TIMER;
    va = O_AUX_TIMER;
    repeat (4) u_pins.flip(3);
    chk("core ext fall", O_CORE_TIMER, v + 16'h0002);
    I_CAP_CLEAR_EN = 1'h0;
    I_CAP_EDGE = dual_timer_pkg::EDGE_NONE;
    u_pins.flip(6);
    chk("no capture", {15'h0000, O_CAPTURE_EVT}, 16'h0000);
    I_CAP_EDGE = dual_timer_pkg::EDGE_BOTH;
    u_pins.flip(6);
    wait_hi(1'h0);
    chk("capture both", O_CAPTURE_RELOAD, va);
    I_CAP_EDGE = dual_timer_pkg::EDGE_FALL;
    u_pins.flip(6);
    wait_hi(1'h0);
    chk("aux kept", O_AUX_TIMER, va);
    $display("alt source done");
  endtask
  task automatic complete_run();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    step(2);
    I_RST_N = 1'h1;
    test_count();
    test_capture();
    test_wrap();
    test_alt_source();
    complete_run();
  end
endmodule
`default_nettype wire
